// ### logic/mbts_cfg.svh
// Operation
// - start block equals select field plus one
// - mode bit4, resume6, halt8, start9, select11-15
// - mode and block latched on start rise
// - in-progress high while block or sequence runs
// - single mode clears in-progress when block done
// - sequence ends on next setting 0,-1,-2,-3
// - active block number readable during sequence
// - start falling stops axis with block ramp
// - resume plus start rise continues interrupted block
// - resume without valid block uses select field
// - resumable block reads -1 when none valid
// - target reached when position enters window
// - halt stops block, stays operation enabled
// - under halt target reached at zero speed
// - halt released resumes the interrupted block
// - gear-coupled bit follows coupled electronic gear
// - table mode selected by operating mode -1
// - 020f,0a0f,120f single; 021f sequence start
// - 004f resumes single, 005f resumes sequence
// - status 0xn337 running, 0xn637 target reached
`ifndef MBTS_CFG_SVH
`define MBTS_CFG_SVH
`define MBTS_OFS_CTRL     8'h00
`define MBTS_OFS_MODE     8'h04
`define MBTS_OFS_STAT     8'h08
`define MBTS_OFS_ACTIVE   8'h0c
`define MBTS_OFS_RESUME   8'h10
`define MBTS_OFS_TABLE    8'h80
`define MBTS_CW_SEQ       4
`define MBTS_CW_RESUME    6
`define MBTS_CW_HALT      8
`define MBTS_CW_START     9
`define MBTS_CW_SEL_LO    11
`define MBTS_CW_SEL_HI    15
`define MBTS_SW_BUSY      8
`define MBTS_SW_REMOTE    9
`define MBTS_SW_GOAL      10
`define MBTS_SW_GEAR      12
`define MBTS_SW_FERR      13
`define MBTS_MODE_TABLE   8'hff
`define MBTS_LOW_DISABLED 8'h50
`define MBTS_LOW_READY    8'h31
`define MBTS_LOW_ON       8'h33
`define MBTS_LOW_ENABLED  8'h37
`define MBTS_CTRL_RST     16'h0000
`define MBTS_MODE_RST     8'h00
`define MBTS_NEXT_RST     8'h00
`define MBTS_NONE         32'hffffffff
`endif

// ### logic/mbts_pkg.sv
package mbts_pkg;
    typedef enum logic [1:0] {
        MBTS_IDLE = 2'b00,
        MBTS_RUN  = 2'b01,
        MBTS_HOLD = 2'b11,
        MBTS_STOP = 2'b10
    } mbts_seq_t;
    typedef enum logic [1:0] {
        MBTS_PS_DISABLED = 2'b00,
        MBTS_PS_READY    = 2'b01,
        MBTS_PS_ON       = 2'b11,
        MBTS_PS_ENABLED  = 2'b10
    } mbts_pwr_t;
endpackage : mbts_pkg

// ### logic/mbts_sequencer.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "mbts_cfg.svh"
module mbts_sequencer #(
    parameter int NUM_BLOCKS = 32
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        motion_done,
    input  wire logic        pos_in_window,
    input  wire logic        axis_speed_zero,
    input  wire logic        gear_in_use,
    input  wire logic        gear_coupled,
    input  wire logic        following_error,
    output logic             motion_run,
    output logic             motion_load,
    output logic             motion_ramp_stop,
    output logic      [5:0]  motion_block,
    output logic      [15:0] status_word
);
    import mbts_pkg::*;

    initial begin
        if (NUM_BLOCKS < 1 || NUM_BLOCKS > 32) begin
            $error("NUM_BLOCKS must lie in 1..32");
        end
    end

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [7:0]  mode_reg;
    logic [7:0]  mode_next;
    logic        start_prev_reg;
    logic [7:0]  next_tbl_reg [NUM_BLOCKS];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    mbts_seq_t   seq_reg;
    mbts_seq_t   seq_next;
    mbts_pwr_t   pwr_reg;
    mbts_pwr_t   pwr_next;
    logic        busy_reg;
    logic        busy_next;
    logic        auto_reg;
    logic        auto_next;
    logic [5:0]  blk_reg;
    logic [5:0]  blk_next;
    logic        rsm_ok_reg;
    logic        rsm_ok_next;
    logic [5:0]  rsm_blk_reg;
    logic [5:0]  rsm_blk_next;
    logic        run_reg;
    logic        run_next;
    logic        load_reg;
    logic        load_next;
    logic        ramp_reg;
    logic        ramp_next;
    logic        goal_reg;
    logic        goal_next;
    logic [15:0] stat_reg;
    logic [15:0] stat_next;

    logic        acc;
    logic        wr;
    logic [5:0]  tbl_idx;
    logic        tbl_hit;
    logic        start_rise;
    logic        table_mode;
    logic [5:0]  sel_blk;
    logic signed [7:0] nxt_set;

    assign acc        = psel & penable & pready_reg;
    assign wr         = acc & pwrite;
    assign tbl_idx    = paddr[7:2] - 6'(`MBTS_OFS_TABLE >> 2);
    assign tbl_hit    = paddr >= `MBTS_OFS_TABLE && 32'(tbl_idx) < NUM_BLOCKS;
    assign start_rise = ctrl_reg[`MBTS_CW_START] & ~start_prev_reg;
    assign table_mode = mode_reg == `MBTS_MODE_TABLE;
    assign sel_blk    = {1'b0, ctrl_reg[`MBTS_CW_SEL_HI:`MBTS_CW_SEL_LO]} + 6'h01;
    assign nxt_set    = next_tbl_reg[5'(blk_reg - 6'h01)];

    // zero-wait apb: ready rises in the first access cycle
    always_comb begin
        ctrl_next    = ctrl_reg;
        mode_next    = mode_reg;
        prdata_next  = prdata_reg;
        pready_next  = psel & ~penable;
        pslverr_next = 1'b0;
        if (psel & ~penable) begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = 1'b0;
            unique case (paddr)
                `MBTS_OFS_CTRL:   prdata_next = {16'h0000, ctrl_reg};
                `MBTS_OFS_MODE:   prdata_next = {24'h000000, mode_reg};
                `MBTS_OFS_STAT:   prdata_next = {16'h0000, stat_reg};
                `MBTS_OFS_ACTIVE: prdata_next = {26'h0000000, blk_reg};
                `MBTS_OFS_RESUME: begin
                    prdata_next = rsm_ok_reg ? {26'h0000000, rsm_blk_reg}
                                             : `MBTS_NONE;
                end
                default: begin
                    if (tbl_hit) begin
                        prdata_next = {{24{next_tbl_reg[5'(tbl_idx)][7]}},
                                       next_tbl_reg[5'(tbl_idx)]};
                    end else begin
                        pslverr_next = 1'b1;
                    end
                end
            endcase
            if (pwrite && (paddr == `MBTS_OFS_STAT || paddr == `MBTS_OFS_ACTIVE
                           || paddr == `MBTS_OFS_RESUME)) begin
                pslverr_next = 1'b1;
            end
        end
        if (wr && paddr == `MBTS_OFS_CTRL) begin
            ctrl_next = pwdata[15:0];
        end
        if (wr && paddr == `MBTS_OFS_MODE) begin
            mode_next = pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg       <= `MBTS_CTRL_RST;
            mode_reg       <= `MBTS_MODE_RST;
            start_prev_reg <= 1'b0;
            prdata_reg     <= 32'h0000_0000;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
        end else begin
            ctrl_reg       <= ctrl_next;
            mode_reg       <= mode_next;
            start_prev_reg <= ctrl_reg[`MBTS_CW_START];
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
        end
    end

    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_tbl
        logic [7:0] ent_next;
        always_comb begin
            ent_next = next_tbl_reg[i];
            if (wr && tbl_hit && 32'(tbl_idx) == i) begin
                ent_next = pwdata[7:0];
            end
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                next_tbl_reg[i] <= `MBTS_NEXT_RST;
            end else begin
                next_tbl_reg[i] <= ent_next;
            end
        end
    end

    // reduced power-state walk, enough for the bring-up sequence
    always_comb begin
        pwr_next = pwr_reg;
        if (!ctrl_reg[1]) begin
            pwr_next = MBTS_PS_DISABLED;
        end else begin
            unique case (pwr_reg)
                MBTS_PS_DISABLED: begin
                    if (ctrl_reg[2:0] == 3'h6) pwr_next = MBTS_PS_READY;
                end
                MBTS_PS_READY: begin
                    if (ctrl_reg[3:0] == 4'h7) pwr_next = MBTS_PS_ON;
                end
                MBTS_PS_ON: begin
                    if (ctrl_reg[3:0] == 4'hf) pwr_next = MBTS_PS_ENABLED;
                    if (ctrl_reg[2:0] == 3'h6) pwr_next = MBTS_PS_READY;
                end
                MBTS_PS_ENABLED: begin
                    if (ctrl_reg[3:0] == 4'h7) pwr_next = MBTS_PS_ON;
                    if (ctrl_reg[2:0] == 3'h6) pwr_next = MBTS_PS_READY;
                end
            endcase
        end
    end

    always_comb begin
        seq_next     = seq_reg;
        busy_next    = busy_reg;
        auto_next    = auto_reg;
        blk_next     = blk_reg;
        rsm_ok_next  = rsm_ok_reg;
        rsm_blk_next = rsm_blk_reg;
        run_next     = run_reg;
        load_next    = 1'b0;
        ramp_next    = ramp_reg;
        unique case (seq_reg)
            MBTS_IDLE: begin
                if (start_rise && table_mode && pwr_reg == MBTS_PS_ENABLED) begin
                    auto_next = ctrl_reg[`MBTS_CW_SEQ];
                    if (ctrl_reg[`MBTS_CW_RESUME] && rsm_ok_reg) begin
                        blk_next = rsm_blk_reg;
                    end else begin
                        blk_next = sel_blk;
                    end
                    rsm_ok_next = 1'b0;
                    busy_next   = 1'b1;
                    run_next    = 1'b1;
                    load_next   = 1'b1;
                    ramp_next   = 1'b0;
                    seq_next    = MBTS_RUN;
                end
            end
            MBTS_RUN: begin
                if (!ctrl_reg[`MBTS_CW_START] || pwr_reg != MBTS_PS_ENABLED) begin
                    run_next     = 1'b0;
                    ramp_next    = 1'b1;
                    busy_next    = 1'b0;
                    rsm_ok_next  = 1'b1;
                    rsm_blk_next = blk_reg;
                    seq_next     = MBTS_STOP;
                end else if (ctrl_reg[`MBTS_CW_HALT]) begin
                    run_next  = 1'b0;
                    ramp_next = 1'b1;
                    seq_next  = MBTS_HOLD;
                end else if (motion_done) begin
                    // non-positive or out-of-range settings all end the sequence
                    if (auto_reg && nxt_set > 8'sh00
                        && 32'(nxt_set) <= NUM_BLOCKS) begin
                        blk_next  = nxt_set[5:0];
                        load_next = 1'b1;
                    end else begin
                        busy_next = 1'b0;
                        run_next  = 1'b0;
                        seq_next  = MBTS_IDLE;
                    end
                end
            end
            MBTS_HOLD: begin
                if (!ctrl_reg[`MBTS_CW_START] || pwr_reg != MBTS_PS_ENABLED) begin
                    busy_next    = 1'b0;
                    rsm_ok_next  = 1'b1;
                    rsm_blk_next = blk_reg;
                    seq_next     = MBTS_STOP;
                end else if (!ctrl_reg[`MBTS_CW_HALT]) begin
                    run_next  = 1'b1;
                    ramp_next = 1'b0;
                    seq_next  = MBTS_RUN;
                end
            end
            MBTS_STOP: begin
                // new start only once the axis is at rest
                if (axis_speed_zero) begin
                    ramp_next = 1'b0;
                    seq_next  = MBTS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seq_reg     <= MBTS_IDLE;
            pwr_reg     <= MBTS_PS_DISABLED;
            busy_reg    <= 1'b0;
            auto_reg    <= 1'b0;
            blk_reg     <= 6'h00;
            rsm_ok_reg  <= 1'b0;
            rsm_blk_reg <= 6'h00;
            run_reg     <= 1'b0;
            load_reg    <= 1'b0;
            ramp_reg    <= 1'b0;
        end else begin
            seq_reg     <= seq_next;
            pwr_reg     <= pwr_next;
            busy_reg    <= busy_next;
            auto_reg    <= auto_next;
            blk_reg     <= blk_next;
            rsm_ok_reg  <= rsm_ok_next;
            rsm_blk_reg <= rsm_blk_next;
            run_reg     <= run_next;
            load_reg    <= load_next;
            ramp_reg    <= ramp_next;
        end
    end

    always_comb begin
        if (ctrl_reg[`MBTS_CW_HALT]) begin
            goal_next = axis_speed_zero;
        end else begin
            // kept after the block ends so a finished block still reads as reached
            goal_next = pos_in_window && !load_reg;
        end
        stat_next = 16'h0000;
        unique case (pwr_reg)
            MBTS_PS_DISABLED: stat_next[7:0] = `MBTS_LOW_DISABLED;
            MBTS_PS_READY:    stat_next[7:0] = `MBTS_LOW_READY;
            MBTS_PS_ON:       stat_next[7:0] = `MBTS_LOW_ON;
            MBTS_PS_ENABLED:  stat_next[7:0] = `MBTS_LOW_ENABLED;
        endcase
        stat_next[`MBTS_SW_BUSY]   = busy_reg;
        stat_next[`MBTS_SW_REMOTE] = pwr_reg == MBTS_PS_ENABLED;
        stat_next[`MBTS_SW_GOAL]   = goal_reg;
        stat_next[`MBTS_SW_GEAR]   = gear_in_use & gear_coupled;
        stat_next[`MBTS_SW_FERR]   = following_error;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            goal_reg <= 1'b0;
            stat_reg <= 16'h0000;
        end else begin
            goal_reg <= goal_next;
            stat_reg <= stat_next;
        end
    end

    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign motion_run       = run_reg;
    assign motion_load      = load_reg;
    assign motion_ramp_stop = ramp_reg;
    assign motion_block     = blk_reg;
    assign status_word      = stat_reg;

    property p_start_sel;
        @(posedge mclk) disable iff (rst)
        (seq_reg == MBTS_IDLE && start_rise && table_mode && pwr_reg == MBTS_PS_ENABLED
         && !ctrl_reg[`MBTS_CW_RESUME])
        |=> blk_reg == $past(sel_blk) && busy_reg && load_reg;
    endproperty
    a_start_sel: assert property (p_start_sel) else $error("start block wrong");

    property p_mode_latch;
        @(posedge mclk) disable iff (rst)
        seq_reg != MBTS_IDLE && $stable(seq_reg) |-> $stable(auto_reg);
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode changed mid run");

    property p_busy;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_RUN |-> busy_reg ##1 stat_reg[`MBTS_SW_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy low while running");

    property p_single_end;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_RUN && !auto_reg && motion_done && ctrl_reg[`MBTS_CW_START]
        && !ctrl_reg[`MBTS_CW_HALT] && pwr_reg == MBTS_PS_ENABLED
        |=> !busy_reg ##1 !stat_reg[`MBTS_SW_BUSY];
    endproperty
    a_single_end: assert property (p_single_end) else $error("single block not ended");

    property p_seq_end;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_RUN && auto_reg && motion_done && nxt_set <= 8'sh00
        && ctrl_reg[`MBTS_CW_START] && !ctrl_reg[`MBTS_CW_HALT]
        && pwr_reg == MBTS_PS_ENABLED |=> seq_reg == MBTS_IDLE && !busy_reg;
    endproperty
    a_seq_end: assert property (p_seq_end) else $error("sequence did not end");

    property p_stop;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_RUN && !ctrl_reg[`MBTS_CW_START]
        |=> ramp_reg && !run_reg && rsm_ok_reg && rsm_blk_reg == $past(blk_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("interrupt not handled");

    property p_resume;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_IDLE && start_rise && table_mode && pwr_reg == MBTS_PS_ENABLED
        && ctrl_reg[`MBTS_CW_RESUME] && rsm_ok_reg |=> blk_reg == $past(rsm_blk_reg);
    endproperty
    a_resume: assert property (p_resume) else $error("resume block wrong");

    property p_none;
        @(posedge mclk) disable iff (rst)
        psel && !penable && paddr == `MBTS_OFS_RESUME && !rsm_ok_reg
        |=> prdata_reg == `MBTS_NONE;
    endproperty
    a_none: assert property (p_none) else $error("resume not -1");

    property p_halt;
        @(posedge mclk) disable iff (rst)
        seq_reg == MBTS_RUN && ctrl_reg[`MBTS_CW_START] && ctrl_reg[`MBTS_CW_HALT]
        && pwr_reg == MBTS_PS_ENABLED
        |=> seq_reg == MBTS_HOLD && ramp_reg && busy_reg;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not applied");

    property p_halt_goal;
        @(posedge mclk) disable iff (rst)
        ctrl_reg[`MBTS_CW_HALT] |=> goal_reg == $past(axis_speed_zero);
    endproperty
    a_halt_goal: assert property (p_halt_goal) else $error("halt target wrong");

    property p_gear;
        @(posedge mclk) disable iff (rst)
        ##1 stat_reg[`MBTS_SW_GEAR] == $past(gear_in_use & gear_coupled);
    endproperty
    a_gear: assert property (p_gear) else $error("gear bit wrong");
endmodule : mbts_sequencer

// ### bench/mbts_motion_model.sv
`timescale 1ns/1ps
module mbts_motion_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       motion_run,
    input  wire logic       motion_load,
    input  wire logic       motion_ramp_stop,
    input  wire logic       stall,
    input  wire logic [3:0] lat,
    output logic            motion_done,
    output logic            pos_in_window,
    output logic            axis_speed_zero
);
    logic [3:0] cnt_reg;
    logic [2:0] spd_reg;
    // travel time per block; stall freezes it so a block stays in flight
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            spd_reg <= 3'h0;
            motion_done <= 1'b0;
            pos_in_window <= 1'b0;
        end else begin
            motion_done <= 1'b0;
            // axis needs a few cycles of ramp before it is at rest
            if (motion_run && !motion_ramp_stop) begin
                spd_reg <= 3'h4;
            end else if (spd_reg != 3'h0) begin
                spd_reg <= spd_reg - 3'h1;
            end
            if (motion_load) begin
                cnt_reg <= lat;
                pos_in_window <= 1'b0;
            end else if (motion_run && !stall && cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
                pos_in_window <= (cnt_reg <= 4'h3);
                motion_done <= (cnt_reg == 4'h1);
            end
        end
    end
    assign axis_speed_zero = (spd_reg == 3'h0);
endmodule : mbts_motion_model

// ### bench/mbts_sequencer_test.sv
`timescale 1ns/1ps
module mbts_sequencer_test;
    localparam logic [7:0]  CW = 8'h00;
    localparam logic [7:0]  ST = 8'h08;
    localparam logic [7:0]  AC = 8'h0c;
    localparam logic [7:0]  RS = 8'h10;
    localparam logic [31:0] NO = 32'hffffffff;
    localparam logic [4:0]  SELS[6] = '{5'd0, 5'd1, 5'd2, 5'd3, 5'd16, 5'd31};
    localparam logic [7:0]  ENDS[4] = '{8'h00, 8'hff, 8'hfe, 8'hfd};
    localparam logic [15:0] UPW[3] = '{16'h0006, 16'h0007, 16'h000f};
    localparam logic [15:0] UPS[3] = '{16'h0031, 16'h0033, 16'h0237};
    logic        mclk = 1'b0;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready, pslverr, motion_done, pos_in_window, axis_speed_zero;
    logic        gear_in_use;
    logic        gear_coupled;
    logic        following_error;
    logic        motion_run, motion_load, motion_ramp_stop, stall;
    logic [5:0]  motion_block, b;
    logic [15:0] status_word;
    logic [3:0]  lat;
    logic [33:0] e;
    logic [33:0] acc_q[$];
    logic [5:0]  blk_q[$];
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cycles = 0;

    initial begin
        forever #10 mclk = ~mclk;
    end

    mbts_sequencer #(.NUM_BLOCKS(32)) dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motion_done(motion_done),
        .pos_in_window(pos_in_window), .axis_speed_zero(axis_speed_zero),
        .gear_in_use(gear_in_use), .gear_coupled(gear_coupled),
        .following_error(following_error), .motion_run(motion_run),
        .motion_load(motion_load), .motion_ramp_stop(motion_ramp_stop),
        .motion_block(motion_block), .status_word(status_word));

    mbts_motion_model model (.mclk(mclk), .rst(rst), .motion_run(motion_run),
        .motion_load(motion_load), .motion_ramp_stop(motion_ramp_stop), .stall(stall),
        .lat(lat), .motion_done(motion_done), .pos_in_window(pos_in_window),
        .axis_speed_zero(axis_speed_zero));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // watcher: each answer or load is matched against the oldest note
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            give_verdict();
        end
        if (psel && penable && pready) begin
            e = (acc_q.size() != 0) ? acc_q.pop_front() : 34'h3ffffffff;
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (e[33]) chk("prdata", prdata, e[31:0]);
        end
        if (motion_load) begin
            b = (blk_q.size() != 0) ? blk_q.pop_front() : 6'h3f;
            chk("block", {26'h0, motion_block}, {26'h0, b});
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] x);
        acc_q.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b00, 32'h0});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {2'b10, x});
    endtask : rd

    task automatic wait_busy(input logic v);
        int n = 0;
        while (status_word[8] !== v && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk("busy", {31'h0, status_word[8]}, {31'h0, v});
    endtask : wait_busy

    task automatic run_blk(input logic [31:0] w);
        wr(CW, 32'h000f);
        wr(CW, w);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(ST, 32'h0637);
    endtask : run_blk

    initial begin
        logic [4:0] sel;
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        gear_in_use <= 1'b0;
        gear_coupled <= 1'b0;
        following_error <= 1'b0;
        stall <= 1'b0;
        lat <= 4'h4;
        void'($urandom(32'h0e546ac6));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ST, 32'h0050);
        wr(CW, 32'h0);
        wr(8'h04, 32'hff);
        for (int i = 0; i < 3; i++) begin
            wr(CW, {16'h0, UPW[i]});
            rd(ST, {16'h0, UPS[i]});
        end
        apb(1'b0, 8'h40, 32'h0, {2'b11, 32'h0});
        apb(1'b1, ST, 32'hffff, {2'b01, 32'h0});
        rd(ST, 32'h0237);
        for (int i = 0; i < 8; i++) begin
            sel = (i < 6) ? SELS[i] : 5'($urandom);
            lat <= 4'(3 + $urandom % 12);
            blk_q.push_back({1'b0, sel} + 6'h1);
            run_blk({16'h0, sel, 11'h20f});
        end
        wr(CW, {16'h0, sel, 11'h20f});
        chk("run held start", {31'h0, motion_run}, 32'h0);
        wr(8'h80, 32'h5);
        for (int i = 0; i < 4; i++) begin
            wr(8'h90, {24'h0, ENDS[i]});
            blk_q.push_back(6'd1);
            blk_q.push_back(6'd5);
            run_blk(32'h021f);
        end
        rd(8'h90, 32'hfffffffd);
        wr(8'h8c, 32'h5);
        wr(8'h90, 32'h0);
        stall <= 1'b1;
        blk_q.push_back(6'd4);
        wr(CW, 32'h000f);
        wr(CW, 32'h1a1f);
        wait_busy(1'b1);
        wr(CW, 32'hfa1f);
        rd(AC, 32'h4);
        rd(ST, 32'h0337);
        rd(RS, NO);
        wr(CW, 32'h001f);
        chk("run", {31'h0, motion_run}, 32'h0);
        chk("ramp", {31'h0, motion_ramp_stop}, 32'h1);
        repeat (10) @(posedge mclk);
        rd(RS, 32'h4);
        stall <= 1'b0;
        blk_q.push_back(6'd4);
        blk_q.push_back(6'd5);
        wr(CW, 32'h005f);
        // resume only arms; the start rise launches it
        wr(CW, 32'h025f);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(RS, NO);
        blk_q.push_back(6'd2);
        run_blk(32'h0a4f);
        stall <= 1'b1;
        blk_q.push_back(6'd1);
        wr(CW, 32'h000f);
        wr(CW, 32'h020f);
        wait_busy(1'b1);
        wr(CW, 32'h030f);
        chk("halt run", {31'h0, motion_run}, 32'h0);
        chk("halt ramp", {31'h0, motion_ramp_stop}, 32'h1);
        repeat (8) @(posedge mclk);
        rd(ST, 32'h0737);
        stall <= 1'b0;
        wr(CW, 32'h020f);
        wait_busy(1'b0);
        rd(ST, 32'h0637);
        for (int i = 0; i < 8; i++) begin
            gear_in_use <= i[0];
            gear_coupled <= i[1];
            following_error <= i[2];
            repeat (3) @(posedge mclk);
            rd(ST, {18'h0, i[2], i[1] & i[0], 12'h637});
        end
        give_verdict();
    end
endmodule : mbts_sequencer_test
